// [rtl/drib_addr_counter.sv]
`timescale 1ns/10ps
`default_nettype none
module drib_addr_counter (
  input wire logic clk,                       // processor clock
  input wire logic rst,                       // synchronous reset
  input wire logic step,                      // advance after a refresh
  output logic [12:0] addr                    // refresh address A13..A1
);

  logic [6:0] lfsr_q;
  logic [6:0] lfsr_d;
  logic [5:0] bin_q;
  logic [5:0] bin_d;
  logic fb;

  // ---------------------------------------------------------------
  // shift register and binary counter
  // ---------------------------------------------------------------
  // full-cycle shift register
  // the zero-detect term splices the all-zero state into the cycle,
  // so all 128 codes appear instead of the usual 127
  always_comb begin
    fb = lfsr_q[6] ^ lfsr_q[5] ^ (lfsr_q[5:0] == 6'h00);
    lfsr_d = lfsr_q;
    bin_d = bin_q;
    if (step) begin
      lfsr_d = {lfsr_q[5:0], fb};
      if ({lfsr_q[5:0], fb} == drib_pkg::LFSR_RST) begin
        bin_d = bin_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_q <= drib_pkg::LFSR_RST;
      bin_q <= drib_pkg::BIN_RST;
    end else begin
      lfsr_q <= lfsr_d;
      bin_q <= bin_d;
    end
  end

  assign addr = {bin_q, lfsr_q};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [7:0] seen_q;
  always_ff @(posedge clk) begin
    if (rst || (step && lfsr_d == drib_pkg::LFSR_RST)) begin
      seen_q <= 8'h00;
    end else if (step) begin
      seen_q <= seen_q + 8'h01;
    end
  end

  chk_lfsr_period: assert property (@(posedge clk) disable iff (rst)
    seen_q <= 8'h7f)
    else $error("shift register period exceeds 128");
  chk_bin_advance: assert property (@(posedge clk) disable iff (rst)
    step && lfsr_d == drib_pkg::LFSR_RST |=> bin_q == $past(bin_q) + 6'h01)
    else $error("binary counter did not advance on wrap");
  chk_bin_hold: assert property (@(posedge clk) disable iff (rst)
    !(step && lfsr_d == drib_pkg::LFSR_RST) |=> $stable(bin_q))
    else $error("binary counter moved without a wrap");

endmodule
`default_nettype wire

// [rtl/drib_pkg.sv]
package drib_pkg;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_BASE = 16'hf4a0;
  localparam logic [15:0] IDX_RELOAD = 16'hf4a2;
  localparam logic [15:0] IDX_CONTROL = 16'hf4a4;
  localparam logic [15:0] IDX_ADDRESS = 16'hf4a6;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int RELOAD_W = 10;
  localparam int BASE_W = 12;
  localparam int LFSR_W = 7;
  localparam int BIN_W = 6;
  localparam int CTRL_EN_BIT = 15;
  localparam logic [9:0] RELOAD_RST = 10'h000;
  localparam logic [11:0] BASE_RST = 12'h000;
  localparam logic [9:0] COUNT_ONE = 10'h001;
  localparam logic [6:0] LFSR_RST = 7'h00;
  localparam logic [5:0] BIN_RST = 6'h00;

  // refresh request state
  typedef enum logic [0:0] {
    REQ_IDLE = 1'b0,
    REQ_PENDING = 1'b1
  } drib_req_t;

endpackage

// [rtl/drib_refresh.sv]
`timescale 1ns/10ps
`default_nettype none
module drib_refresh #(
  parameter int AW = 20                       // apb address width
) (
  input wire logic clk,                       // processor clock, 50 MHz
  input wire logic rst,                       // synchronous reset
  input wire logic psel,                      // apb select
  input wire logic penable,                   // apb access phase
  input wire logic pwrite,                    // apb write
  input wire logic [AW-1:0] paddr,            // apb byte address
  input wire logic [31:0] pwdata,             // apb write data
  output logic [31:0] prdata,                 // apb read data
  output logic pready,                        // apb ready
  output logic pslverr,                       // apb error, unmapped address
  input wire logic refreshDone,               // refresh bus cycle finished
  output logic refreshReq,                    // refresh request pending
  output logic [25:1] refreshAddr             // refresh address A25..A1
);

  logic [9:0] reload_q, reload_d;
  logic [11:0] base_q, base_d;
  logic enable_q, enable_d;
  logic [9:0] count_q, count_d;
  logic enPrev_q, enPrev_d;
  drib_pkg::drib_req_t req_q, req_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [25:1] raddr_q, raddr_d;
  logic [12:0] lowAddr;
  logic timeout;
  logic wrDone;
  logic [3:0] hit;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // decode one register index against the byte address
  function automatic logic isReg(input logic [AW-1:0] a,
                                 input logic [15:0] idx);
    isReg = (a == AW'({idx, 2'b00}));
  endfunction

  assign hit[0] = isReg(paddr, drib_pkg::IDX_BASE);
  assign hit[1] = isReg(paddr, drib_pkg::IDX_RELOAD);
  assign hit[2] = isReg(paddr, drib_pkg::IDX_CONTROL);
  assign hit[3] = isReg(paddr, drib_pkg::IDX_ADDRESS);
  // one wait state: ready is a flop, so the access completes next edge
  assign wrDone = psel && penable && pready_q && pwrite;

  // ---------------------------------------------------------------
  // apb slave and registers
  // ---------------------------------------------------------------
  // reserved bits are not stored and read as zero, except bit 0 of the address register, which reads as one
  always_comb begin
    reload_d = reload_q;
    base_d = base_q;
    enable_d = enable_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = psel && penable && !pready_q;
    if (psel && penable && !pready_q) begin
      pslverr_d = (hit == 4'h0);
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        if (hit[2]) begin
          prdata_d = {16'h0000, enable_q, 5'h00, count_q};
        end
        if (hit[1]) begin
          prdata_d = {22'h000000, reload_q};
        end
        if (hit[0]) begin
          prdata_d = {20'h00000, base_q};
        end
        if (hit[3]) begin
          prdata_d = {18'h00000, lowAddr, 1'b1};
        end
      end
    end
    if (wrDone) begin
      if (hit[1]) begin
        reload_d = pwdata[drib_pkg::RELOAD_W-1:0];
      end
      if (hit[0]) begin
        base_d = pwdata[drib_pkg::BASE_W-1:0];
      end
      if (hit[2]) begin
        enable_d = pwdata[drib_pkg::CTRL_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload_q <= drib_pkg::RELOAD_RST;
      base_q <= drib_pkg::BASE_RST;
      enable_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      reload_q <= reload_d;
      base_q <= base_d;
      enable_q <= enable_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // interval timer and request
  // ---------------------------------------------------------------
  // a reload written while running takes effect at the next expiry
  always_comb begin
    enPrev_d = enable_q;
    count_d = count_q;
    timeout = 1'b0;
    if (enable_q && !enPrev_q) begin
      count_d = reload_q;
    end else if (enable_q) begin
      if (count_q == drib_pkg::COUNT_ONE) begin
        count_d = reload_q;
        timeout = 1'b1;
      end else begin
        count_d = count_q - 10'h001;
      end
    end
  end

  // a new timeout in the cycle the previous refresh ends wins
  always_comb begin
    req_d = req_q;
    if (refreshDone) begin
      req_d = drib_pkg::REQ_IDLE;
    end
    if (timeout && (req_q == drib_pkg::REQ_IDLE || refreshDone)) begin
      req_d = drib_pkg::REQ_PENDING;
    end
    raddr_d = {base_q, lowAddr};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 10'h000;
      enPrev_q <= 1'b0;
      req_q <= drib_pkg::REQ_IDLE;
      raddr_q <= 25'h0000000;
    end else begin
      count_q <= count_d;
      enPrev_q <= enPrev_d;
      req_q <= req_d;
      raddr_q <= raddr_d;
    end
  end

  drib_addr_counter u_addr (
    .clk(clk),
    .rst(rst),
    .step(refreshDone && req_q == drib_pkg::REQ_PENDING),
    .addr(lowAddr)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign refreshReq = (req_q == drib_pkg::REQ_PENDING);
  assign refreshAddr = raddr_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence expiry_s;
    enable_q && enPrev_q && count_q == 10'h001;
  endsequence
  sequence reload_s;
    count_q == $past(reload_q);
  endsequence

  chk_expiry_reload: assert property (@(posedge clk) disable iff (rst)
    expiry_s ##1 1'b1 |-> reload_s)
    else $error("counter not reloaded after reaching one");
  chk_count_down: assert property (@(posedge clk) disable iff (rst)
    enable_q && enPrev_q && count_q != 10'h001 |=>
      count_q == $past(count_q) - 10'h001)
    else $error("interval counter did not decrement");
  chk_req_raise: assert property (@(posedge clk) disable iff (rst)
    expiry_s ##0 !refreshReq |=> refreshReq)
    else $error("expiry did not raise a request");
  chk_req_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(refreshReq) |-> $past(timeout))
    else $error("request raised without expiry");
  chk_disabled_hold: assert property (@(posedge clk) disable iff (rst)
    !enable_q |=> $stable(count_q) && !$rose(refreshReq))
    else $error("disabled unit changed count or raised request");
  chk_base_out: assert property (@(posedge clk) disable iff (rst)
    ##1 refreshAddr[25:14] == $past(base_q))
    else $error("base bits not on refresh address");
  chk_ctrl_read: assert property (@(posedge clk) disable iff (rst)
    psel && penable && !pready_q && !pwrite && hit[2] |=>
      prdata[9:0] == $past(count_q) && pready)
    else $error("control read did not return count");
  chk_apb_ready: assert property (@(posedge clk) disable iff (rst)
    psel && penable && !pready_q |=> pready ##1 !pready)
    else $error("ready not a single cycle pulse");

endmodule
`default_nettype wire

// [verification/dram_refresh_interval_base_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin \
  nMismatch++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); \
  end end
module dram_refresh_interval_base_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic refreshDone;
  logic refreshReq;
  logic [25:1] refreshAddr;
  logic [7:0] delay = 8'h00;
  logic [31:0] rd;
  logic [31:0] rdOld;
  logic err;
  bit seen [128];
  int nMismatch = 0;
  int totalChecks = 0;
  int cyc = 0;
  int lastRise = 0;
  int i;

  always #10 clk = ~clk;

  drib_refresh dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refreshDone(refreshDone), .refreshReq(refreshReq),
    .refreshAddr(refreshAddr));

  drib_dram_model far_u (.clk(clk), .rst(rst), .refreshReq(refreshReq),
    .delay(delay), .refreshDone(refreshDone));

  task printVerdict;
    if (nMismatch == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      nMismatch++;
      printVerdict;
    end
  end

  // ------------------------------------------------
  // bus tasks
  // ------------------------------------------------
  // one transfer; pready is sampled at the edge, before its update lands
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    // a slave that never answers is a failure, not a silent skip
    if (pready !== 1'b1) begin
      nMismatch++;
      $display("MISMATCH t=%0t no ready from slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // next low-to-high change of the request, bounded
  task waitRise;
    int n;
    n = 0;
    while (refreshReq !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk);
    end
    while (refreshReq !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    // a request that never rises counts against the run
    if (refreshReq !== 1'b1) begin
      nMismatch++;
      $display("MISMATCH t=%0t refresh request never rose", $time);
    end
  endtask

  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, drib_pkg::IDX_RELOAD, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, drib_pkg::IDX_CONTROL, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b1, drib_pkg::IDX_RELOAD, 32'h000003ff);
    apb(1'b0, drib_pkg::IDX_RELOAD, 32'h0);
    `CHK(rd, 32'h000003ff)
    apb(1'b1, drib_pkg::IDX_RELOAD, 32'h00000006);
    apb(1'b1, drib_pkg::IDX_BASE, 32'h00000abc);
    apb(1'b0, drib_pkg::IDX_BASE, 32'h0);
    `CHK(rd, 32'h00000abc)
    // unmapped word answers with an error and zero data
    apb(1'b0, 16'hf4a8, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h00000000)
    repeat (30) @(posedge clk);
    `CHK(refreshReq, 1'b0)
    // alternate prompt and slow service; the slow case spans two
    // ignored timeouts and ends a cycle before the next one, so
    // each rise is served once and the address steps once per rise
    apb(1'b1, drib_pkg::IDX_CONTROL, 32'h00008000);
    for (i = 0; i <= 128; i++) begin
      delay <= (i % 2 == 1) ? 8'h0e : 8'h00;
      waitRise;
      if (i == 1) `CHK(cyc - lastRise, 6)
      lastRise = cyc;
      `CHK(refreshAddr[25:14], 12'habc)
      if (i < 128) begin
        `CHK(refreshAddr[13:8], 6'h00)
        `CHK(seen[refreshAddr[7:1]], 1'b0)
        seen[refreshAddr[7:1]] = 1'b1;
      end else begin
        `CHK(refreshAddr[13:1], 13'h0080)
      end
    end
    apb(1'b0, drib_pkg::IDX_CONTROL, 32'h0);
    `CHK(rd[15], 1'b1)
    `CHK(rd[9:0] != 10'h000 && rd[9:0] <= 10'h006, 1'b1)
    apb(1'b0, drib_pkg::IDX_ADDRESS, 32'h0);
    `CHK(rd[0], 1'b1)
    `CHK(rd[13:8], 6'h01)
    // disabled: count frozen and no new request
    apb(1'b1, drib_pkg::IDX_CONTROL, 32'h0);
    repeat (30) @(posedge clk);
    apb(1'b0, drib_pkg::IDX_CONTROL, 32'h0);
    rdOld = rd;
    repeat (40) @(posedge clk);
    `CHK(refreshReq, 1'b0)
    apb(1'b0, drib_pkg::IDX_CONTROL, 32'h0);
    `CHK(rd, rdOld)
    // mid-run reset returns the reload, base and address registers to their cleared values
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, drib_pkg::IDX_RELOAD, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, drib_pkg::IDX_BASE, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, drib_pkg::IDX_ADDRESS, 32'h0);
    `CHK(rd, 32'h00000001)
    printVerdict;
  end
endmodule
`default_nettype wire

// [verification/drib_dram_model.sv]
`timescale 1ns/10ps
`default_nettype none
module drib_dram_model (
  input wire logic clk,         // processor clock
  input wire logic rst,         // synchronous reset
  input wire logic refreshReq,  // pending refresh request
  input wire logic [7:0] delay, // service latency in cycles
  output logic refreshDone      // one-cycle completion pulse
);
  // ------------------------------------------------
  // refresh bus side
  // ------------------------------------------------
  logic [7:0] waitQ;
  logic busyQ;
  // one completion per request, never while idle
  // latency is latched when a request is seen, so a slow case
  // leaves the request pending across several timeouts
  always_ff @(posedge clk) begin
    refreshDone <= 1'b0;
    if (rst) begin
      busyQ <= 1'b0;
      waitQ <= 8'h00;
    end else if (refreshDone) begin
      busyQ <= 1'b0;
    end else if (refreshReq && !busyQ) begin
      busyQ <= 1'b1;
      waitQ <= delay;
    end else if (busyQ && waitQ != 8'h00) begin
      waitQ <= waitQ - 8'h01;
    end else if (busyQ) begin
      refreshDone <= 1'b1;
    end
  end
endmodule
`default_nettype wire
